//--- rtl/ocbe_pkg.sv
// Constants shared by the overcurrent blanking and edge select block.
// Assumes an 8-bit register port with 16-bit addresses.
package ocbe_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned NUM_CHAN = 3;
  localparam int unsigned NUM_SENSE = 2;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned MAG_W = 7;
  localparam int unsigned POL_BIT = 7;
  localparam int unsigned BLANK_W = 8;
  // Register map
  localparam logic [15:0] SENSE_A_SEL_ADDR = 16'hFE6B;
  localparam logic [15:0] SENSE_B_SEL_ADDR = 16'hFE6C;
  localparam logic [15:0] FORCE_EN_ADDR = 16'hFE6D;
  localparam logic [15:0] GAIN_TRIM_ADDR = 16'hFE6E;
  localparam logic [15:0] BLANK_LEN_ADDR = 16'hFE80;
  localparam logic [15:0] STATUS_ADDR = 16'hFE81;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BLANK_LEN_RESET = 8'h04;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Status fields
  localparam int unsigned ST_BLANK_A = 0;
  localparam int unsigned ST_BLANK_B = 1;
  localparam int unsigned ST_FORCE_LO = 2;
  localparam int unsigned ST_TRIP_A = 6;
  localparam int unsigned ST_TRIP_B = 7;
  // Line indices (line one is index 0)
  localparam int unsigned LINE_ONE = 0;
  localparam int unsigned LINE_TWO = 1;
  localparam int unsigned LINE_THREE = 2;
  localparam int unsigned LINE_FOUR = 3;
  localparam int unsigned LINE_FIVE = 4;
  localparam int unsigned LINE_SIX = 5;
  localparam int unsigned LINE_SEVEN = 6;
  localparam int unsigned LINE_EIGHT = 7;
  // Channel assignment codes of a drive line
  localparam logic [1:0] CHAN_A = 2'h0;
  localparam logic [1:0] CHAN_B = 2'h1;
  localparam logic [1:0] CHAN_C = 2'h2;
  localparam logic [1:0] CHAN_NONE = 2'h3;
endpackage

//--- rtl/ocbe_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the levels are quasi-static per bit; no bus coherence.
module ocbe_sync
  import ocbe_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ocbe_sync_st_t;

  ocbe_sync_st_t st_q;
  ocbe_sync_st_t st_d;

  always_comb begin
    st_d.meta = i_async;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.stable;
endmodule

//--- rtl/ocbe_blanker.sv
// Leading-edge blanking of one secondary current-sense comparator.
// Assumes rising-edge strobes and trip level are in the core clock domain.
module ocbe_blanker
  import ocbe_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Configuration
  input wire logic [SEL_W-1:0] i_edge_sel,
  input wire logic [BLANK_W-1:0] i_blank_len,
  // Events
  input wire logic [SEL_W-1:0] i_rise,
  input wire logic i_trip,
  // Results
  output logic o_blank_active,
  output logic o_trip_qual
);
  typedef enum logic {BL_IDLE, BL_BLANK} ocbe_bl_state_t;

  typedef struct packed {
    ocbe_bl_state_t state;
    logic [BLANK_W-1:0] rem;
    logic active;
    logic trip;
  } ocbe_bl_st_t;

  ocbe_bl_st_t st_q;
  ocbe_bl_st_t st_d;
  logic start;
  logic mask;

  always_comb begin
    st_d = st_q;
    // Only selected edges start a window
    start = |(i_rise & i_edge_sel);
    mask = st_q.state == BL_BLANK;
    unique case (st_q.state)
      BL_IDLE: begin
      end
      BL_BLANK: begin
        st_d.rem = st_q.rem - 8'h01;
        if (st_q.rem == 8'h01) begin
          st_d.state = BL_IDLE;
        end
      end
    endcase
    // A new edge restarts the window, length counts the edge cycle
    if (start && i_blank_len != 8'h00) begin
      mask = 1'b1;
      st_d.rem = i_blank_len - 8'h01;
      st_d.state = (i_blank_len == 8'h01) ? BL_IDLE : BL_BLANK;
    end
    st_d.active = mask;
    st_d.trip = i_trip & ~mask;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '{state: BL_IDLE, rem: '0, active: 1'b0, trip: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_blank_active = st_q.active;
  assign o_trip_qual = st_q.trip;
endmodule

//--- rtl/ocbe_top.sv
// Overcurrent blanking edge select, force-on response and gain trim.
// Assumes PWM lines and channel map come from core-clock logic;
// comparator and trip inputs are asynchronous and are synchronised here.
//
// Design decision made here: the address-and-strobe port.
module ocbe_top
  import ocbe_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Programmed drive lines
  input wire logic [NUM_LINES-1:0] i_pwm_line,
  // Channel of lines three, four, seven, eight
  input wire logic [1:0] i_line_three_chan,
  input wire logic [1:0] i_line_four_chan,
  input wire logic [1:0] i_line_seven_chan,
  input wire logic [1:0] i_line_eight_chan,
  // Comparators
  input wire logic i_secondary_sense_first_cmp,
  input wire logic i_secondary_sense_second_cmp,
  input wire logic [NUM_CHAN-1:0] i_overcurrent_trip,
  // Results
  output logic [NUM_LINES-1:0] o_pwm_line,
  output logic o_secondary_sense_first_trip,
  output logic o_secondary_sense_second_trip,
  output logic o_secondary_sense_first_blank,
  output logic o_secondary_sense_second_blank,
  output logic o_gain_trim_negative,
  output logic [MAG_W-1:0] o_gain_trim_magnitude
);
  typedef struct packed {
    logic [DATA_W-1:0] sel_a;
    logic [DATA_W-1:0] sel_b;
    logic [DATA_W-1:0] force_en;
    logic [DATA_W-1:0] trim;
    logic [BLANK_W-1:0] blank_len;
    logic [DATA_W-1:0] rdata;
    logic [NUM_LINES-1:0] pwm_prev;
    logic [NUM_LINES-1:0] pwm_out;
    logic [NUM_CHAN-1:0] trip_prev;
    logic [SEL_W-1:0] forced;
  } ocbe_top_st_t;

  ocbe_top_st_t st_q;
  ocbe_top_st_t st_d;

  // Synchronised comparator levels
  logic [NUM_CHAN+1:0] cmp_sync;
  logic [NUM_CHAN-1:0] chan_trip;
  logic sense_first;
  logic sense_second;

  // Blanker inputs and results
  logic [NUM_SENSE-1:0] blank_active;
  logic [NUM_SENSE-1:0] trip_qual;
  logic [SEL_W-1:0] sense_rise;
  logic [SEL_W-1:0] sense_sel [NUM_SENSE];
  logic [NUM_SENSE-1:0] sense_cmp;

  // Force-on helpers
  logic [NUM_LINES-1:0] pwm_rise;
  logic [NUM_LINES-1:0] pwm_fall;
  logic [NUM_CHAN-1:0] chan_event;
  logic [SEL_W-1:0] force_line_fall;
  logic [SEL_W-1:0] force_trip;
  logic [1:0] force_chan [SEL_W];
  logic [DATA_W-1:0] status;

  // Trip of the channel a line belongs to; unassigned lines see none
  function automatic logic chan_pick(input logic [1:0] chan, input logic [NUM_CHAN-1:0] ev);
    logic hit;
    hit = 1'b0;
    unique case (chan)
      CHAN_A: hit = ev[0];
      CHAN_B: hit = ev[1];
      CHAN_C: hit = ev[2];
      CHAN_NONE: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Address match, used by write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
    return a == reg_addr;
  endfunction

  // Comparators are analogue, so both flops come first
  ocbe_sync #(
    .W(NUM_CHAN + 2)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_overcurrent_trip, i_secondary_sense_second_cmp, i_secondary_sense_first_cmp}),
    .o_sync(cmp_sync)
  );

  assign sense_first = cmp_sync[0];
  assign sense_second = cmp_sync[1];
  assign chan_trip = cmp_sync[NUM_CHAN+1:2];
  assign sense_cmp = {sense_second, sense_first};

  // Line edges against the previous cycle
  assign pwm_rise = i_pwm_line & ~st_q.pwm_prev;
  assign pwm_fall = ~i_pwm_line & st_q.pwm_prev;

  // Edge bits 0..3 are lines one, two, five, six
  assign sense_rise = {pwm_rise[LINE_SIX], pwm_rise[LINE_FIVE], pwm_rise[LINE_TWO], pwm_rise[LINE_ONE]};
  assign sense_sel[0] = st_q.sel_a[SEL_W-1:0];
  assign sense_sel[1] = st_q.sel_b[SEL_W-1:0];

  // One independent blanker per secondary comparator
  generate
    for (genvar s = 0; s < NUM_SENSE; s++) begin : g_blank
      ocbe_blanker u_blank (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_edge_sel(sense_sel[s]),
        .i_blank_len(st_q.blank_len),
        .i_rise(sense_rise),
        .i_trip(sense_cmp[s]),
        .o_blank_active(blank_active[s]),
        .o_trip_qual(trip_qual[s])
      );
    end
  endgenerate

  // Force bits 0..3 are lines three, four, seven, eight
  assign force_chan[0] = i_line_three_chan;
  assign force_chan[1] = i_line_four_chan;
  assign force_chan[2] = i_line_seven_chan;
  assign force_chan[3] = i_line_eight_chan;
  assign force_line_fall = {pwm_fall[LINE_EIGHT], pwm_fall[LINE_SEVEN], pwm_fall[LINE_FOUR], pwm_fall[LINE_THREE]};

  // Rising trip only, so a held trip cannot re-force after the fall
  assign chan_event = chan_trip & ~st_q.trip_prev;

  generate
    for (genvar f = 0; f < SEL_W; f++) begin : g_force
      assign force_trip[f] = st_q.force_en[f] & chan_pick(force_chan[f], chan_event);
    end
  endgenerate

  // Status view of the block's own state
  always_comb begin
    status = '0;
    status[ST_BLANK_A] = blank_active[0];
    status[ST_BLANK_B] = blank_active[1];
    status[ST_FORCE_LO +: SEL_W] = st_q.forced;
    status[ST_TRIP_A] = trip_qual[0];
    status[ST_TRIP_B] = trip_qual[1];
  end

  always_comb begin
    st_d = st_q;
    st_d.pwm_prev = i_pwm_line;
    st_d.trip_prev = chan_trip;

    // Register writes; reserved high bits are kept as written
    if (i_wr) begin
      if (hit(i_addr, SENSE_A_SEL_ADDR)) begin
        st_d.sel_a = i_wdata;
      end
      if (hit(i_addr, SENSE_B_SEL_ADDR)) begin
        st_d.sel_b = i_wdata;
      end
      if (hit(i_addr, FORCE_EN_ADDR)) begin
        st_d.force_en = i_wdata;
      end
      if (hit(i_addr, GAIN_TRIM_ADDR)) begin
        st_d.trim = i_wdata;
      end
      if (hit(i_addr, BLANK_LEN_ADDR)) begin
        st_d.blank_len = i_wdata;
      end
    end

    // Read data valid in the following cycle only
    st_d.rdata = '0;
    if (i_rd) begin
      if (hit(i_addr, SENSE_A_SEL_ADDR)) begin
        st_d.rdata = st_q.sel_a;
      end else if (hit(i_addr, SENSE_B_SEL_ADDR)) begin
        st_d.rdata = st_q.sel_b;
      end else if (hit(i_addr, FORCE_EN_ADDR)) begin
        st_d.rdata = st_q.force_en;
      end else if (hit(i_addr, GAIN_TRIM_ADDR)) begin
        st_d.rdata = st_q.trim;
      end else if (hit(i_addr, BLANK_LEN_ADDR)) begin
        st_d.rdata = st_q.blank_len;
      end else if (hit(i_addr, STATUS_ADDR)) begin
        st_d.rdata = status;
      end else begin
        st_d.rdata = UNMAPPED_DATA;
      end
    end

    // Force holds until the programmed fall, which wins a tie
    for (int f = 0; f < SEL_W; f++) begin
      st_d.forced[f] = (st_q.forced[f] | force_trip[f]) & ~force_line_fall[f];
    end

    // Drive lines: programmed value, forced ones ORed in
    st_d.pwm_out = i_pwm_line;
    st_d.pwm_out[LINE_THREE] = i_pwm_line[LINE_THREE] | st_d.forced[0];
    st_d.pwm_out[LINE_FOUR] = i_pwm_line[LINE_FOUR] | st_d.forced[1];
    st_d.pwm_out[LINE_SEVEN] = i_pwm_line[LINE_SEVEN] | st_d.forced[2];
    st_d.pwm_out[LINE_EIGHT] = i_pwm_line[LINE_EIGHT] | st_d.forced[3];
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '{
        sel_a: REG_RESET,
        sel_b: REG_RESET,
        force_en: REG_RESET,
        trim: REG_RESET,
        blank_len: BLANK_LEN_RESET,
        rdata: '0,
        pwm_prev: '0,
        pwm_out: '0,
        trip_prev: '0,
        forced: '0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs, all from flops
  assign o_rdata = st_q.rdata;
  assign o_pwm_line = st_q.pwm_out;
  assign o_secondary_sense_first_trip = trip_qual[0];
  assign o_secondary_sense_second_trip = trip_qual[1];
  assign o_secondary_sense_first_blank = blank_active[0];
  assign o_secondary_sense_second_blank = blank_active[1];
  assign o_gain_trim_negative = st_q.trim[POL_BIT];
  assign o_gain_trim_magnitude = st_q.trim[MAG_W-1:0];
endmodule

//--- bench/ocbe_top_properties.sv
// Port checker for ocbe_top, bound into every instance.
// Assumes single-cycle write strobes on the register port.
module ocbe_top_properties
  import ocbe_pkg::*;
(
  // Clock, reset, register writes
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  // Lines and results
  input wire logic [NUM_LINES-1:0] i_pwm_line,
  input wire logic [1:0] i_line_three_chan,
  input wire logic [NUM_LINES-1:0] o_pwm_line,
  input wire logic o_secondary_sense_first_trip,
  input wire logic o_secondary_sense_first_blank,
  input wire logic o_secondary_sense_second_blank,
  input wire logic o_gain_trim_negative,
  input wire logic [MAG_W-1:0] o_gain_trim_magnitude
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sa_q, sb_q, fe_q, gt_q, bl_q, pl_q, up;
  logic hit_a, hit_b;
  assign up = i_pwm_line & ~pl_q;
  assign hit_a = |({up[5], up[4], up[1], up[0]} & sa_q[3:0]);
  assign hit_b = |({up[5], up[4], up[1], up[0]} & sb_q[3:0]);
  // Shadow registers, updated on the same edge as the design
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {sa_q, sb_q, fe_q, gt_q, pl_q} <= 40'h0;
      bl_q <= BLANK_LEN_RESET;
    end else begin
      pl_q <= i_pwm_line;
      if (i_wr && i_addr == SENSE_A_SEL_ADDR) sa_q <= i_wdata;
      if (i_wr && i_addr == SENSE_B_SEL_ADDR) sb_q <= i_wdata;
      if (i_wr && i_addr == FORCE_EN_ADDR) fe_q <= i_wdata;
      if (i_wr && i_addr == GAIN_TRIM_ADDR) gt_q <= i_wdata;
      if (i_wr && i_addr == BLANK_LEN_ADDR) bl_q <= i_wdata;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_blank_a; hit_a && bl_q != 8'h00 |=> o_secondary_sense_first_blank; endproperty
  a_blank_a: assert property (p_blank_a) else $error("first blank missing");
  property p_quiet_a; $rose(o_secondary_sense_first_blank) |-> $past(hit_a); endproperty
  a_quiet_a: assert property (p_quiet_a) else $error("first blank unprompted");
  property p_blank_b; hit_b && bl_q != 8'h00 |=> o_secondary_sense_second_blank; endproperty
  a_blank_b: assert property (p_blank_b) else $error("second blank missing");
  property p_mask; o_secondary_sense_first_blank |-> !o_secondary_sense_first_trip; endproperty
  a_mask: assert property (p_mask) else $error("trip seen in window");
  property p_pass; (o_pwm_line & 8'h33) == ($past(i_pwm_line) & 8'h33); endproperty
  a_pass: assert property (p_pass) else $error("unforced line altered");
  property p_force;
    $rose(o_pwm_line[2]) && !$past(i_pwm_line[2]) |-> fe_q[0] && $past(i_line_three_chan) != CHAN_NONE;
  endproperty
  a_force: assert property (p_force) else $error("line three forced wrongly");
  property p_fall; $fell(i_pwm_line[2]) |=> !o_pwm_line[2]; endproperty
  a_fall: assert property (p_fall) else $error("line three fall late");
  property p_pol; o_gain_trim_negative == gt_q[7]; endproperty
  a_pol: assert property (p_pol) else $error("trim polarity wrong");
  property p_mag; o_gain_trim_magnitude == gt_q[6:0]; endproperty
  a_mag: assert property (p_mag) else $error("trim magnitude wrong");
endmodule
bind ocbe_top ocbe_top_properties ocbe_top_properties_i (.i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
  .i_pwm_line, .i_line_three_chan, .o_pwm_line, .o_secondary_sense_first_trip, .o_secondary_sense_first_blank,
  .o_secondary_sense_second_blank, .o_gain_trim_negative, .o_gain_trim_magnitude);

//--- bench/ocbe_sense_model.sv
// Behavioural comparators and per-channel trip sources.
// Assumes the bench sets wanted levels; outputs move off the clock edge.
module ocbe_sense_model (
  // Wanted levels
  input wire logic [1:0] i_cmp_set,
  input wire logic [2:0] i_trip_set,
  // Levels seen by the block
  output logic [1:0] o_cmp,
  output logic [2:0] o_trip
);
  timeunit 1ns;
  timeprecision 100ps;
  // Skew from the clock so the synchroniser sees truly async edges
  assign #3 o_cmp = i_cmp_set;
  assign #7 o_trip = i_trip_set;
endmodule

//--- bench/tb.sv
// Self-checking bench for ocbe_top with a comparator model.
// Assumes a 50 MHz core clock and the package register map.
module tb
  import ocbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} ocbe_row_t;
  logic clk, nrst, wr, rd, tr_a, tr_b, bl_a, bl_b, neg;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, line, o_line;
  logic [1:0] ch3, ch4, ch7, ch8, cmp_set, cmp;
  logic [2:0] trip_set, trip;
  logic [6:0] mag;
  int n_fail, checks, na, nb;
  int lidx [4] = '{0, 1, 4, 5};
  ocbe_row_t rows [6] = '{'{SENSE_A_SEL_ADDR, 8'h5A, 8'h5A}, '{SENSE_B_SEL_ADDR, 8'hA5, 8'hA5},
    '{FORCE_EN_ADDR, 8'h0F, 8'h0F}, '{GAIN_TRIM_ADDR, 8'h85, 8'h85}, '{BLANK_LEN_ADDR, 8'h03, 8'h03},
    '{16'hFE70, 8'h77, UNMAPPED_DATA}};
  ocbe_top ocbe_top_i (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pwm_line(line), .i_line_three_chan(ch3), .i_line_four_chan(ch4),
    .i_line_seven_chan(ch7), .i_line_eight_chan(ch8), .i_secondary_sense_first_cmp(cmp[0]),
    .i_secondary_sense_second_cmp(cmp[1]), .i_overcurrent_trip(trip), .o_pwm_line(o_line),
    .o_secondary_sense_first_trip(tr_a), .o_secondary_sense_second_trip(tr_b),
    .o_secondary_sense_first_blank(bl_a), .o_secondary_sense_second_blank(bl_b),
    .o_gain_trim_negative(neg), .o_gain_trim_magnitude(mag));
  ocbe_sense_model ocbe_sense_model_i (.i_cmp_set(cmp_set), .i_trip_set(trip_set), .o_cmp(cmp), .o_trip(trip));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  initial begin
    {nrst, wr, rd, addr, wdata, line, cmp_set, trip_set} = '0;
    {ch3, ch4, ch7, ch8} = {CHAN_A, CHAN_B, CHAN_NONE, CHAN_C};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rows[i].e);
    end
    chk({neg, mag}, 8'h85);
    $display("test registers done");
    cmp_set <= 2'b11;
    for (int k = 0; k < 4; k++) begin
      {na, nb} = '0;
      @(posedge clk) line[lidx[k]] <= 1'b1;
      repeat (8) begin
        @(posedge clk) #1;
        na += bl_a;
        nb += bl_b;
        if (bl_a) chk(8'(tr_a), 8'h00);
        if (bl_b) chk(8'(tr_b), 8'h00);
      end
      chk(8'(na), 8'(((8'h5A >> k) & 1) * 3));
      chk(8'(nb), 8'(((8'hA5 >> k) & 1) * 3));
      chk(8'({tr_b, tr_a}), 8'h03);
      @(posedge clk) line <= 8'h00;
      repeat (2) @(posedge clk);
    end
    // Zero length: a selected edge opens no window
    wr_reg(BLANK_LEN_ADDR, 8'h00);
    @(posedge clk) line[LINE_TWO] <= 1'b1;
    repeat (3) begin
      @(posedge clk) #1 chk(8'({bl_b, bl_a}), 8'h00);
    end
    @(posedge clk) line <= 8'h00;
    $display("test blanking done");
    trip_set <= 3'b001;
    repeat (5) @(posedge clk);
    #1 chk(o_line & 8'hCC, 8'h04);
    trip_set <= 3'b101;
    repeat (5) @(posedge clk);
    #1 chk(o_line & 8'hCC, 8'h84);
    @(posedge clk) line[2] <= 1'b1;
    repeat (2) @(posedge clk);
    line[2] <= 1'b0;
    @(posedge clk) #1 chk(o_line & 8'hCC, 8'h80);
    rd_reg(STATUS_ADDR, 8'hE0);
    $display("test force done");
    // Second reset mid-run; lines held low so no edge crosses it
    @(posedge clk) {trip_set, line} <= '0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk({neg, mag}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd_reg(rows[i].a, (i == 4) ? BLANK_LEN_RESET : REG_RESET);
    end
    $display("test reset done");
    wrap_up();
  end
endmodule
